/* File: hdl/sfs_pkg.sv */
// constants for the spi fifo count and input select block
// assumes an 8-bit special-function-register bus on the core clock
package sfs_pkg;
    localparam logic [7:0] SFS_FILL_COUNTS_ADDR = 8'h00_F7;
    localparam logic [7:0] SFS_SOURCE_SELECT_ADDR = 8'h00_DF;
    localparam int SFS_TX_LEVEL_LSB = 4;
    localparam int SFS_RX_LEVEL_LSB = 0;
    localparam int SFS_LEVEL_WIDTH = 3;
    localparam int SFS_SLAVE_CLOCK_BIT = 2;
    localparam int SFS_MASTER_DATA_BIT = 1;
    localparam int SFS_SLAVE_DATA_BIT = 0;
    localparam logic [2:0] SFS_SELECT_RESET = 3'h0;
    localparam logic [2:0] SFS_LEVEL_RESET = 3'h0;
    localparam logic [7:0] SFS_READ_IDLE = 8'h00;
endpackage

/* File: hdl/sfs_spi_fifo_count_and_input_select.sv */
// fill-level status and input routing for the spi unit
// assumes sfr bus inputs synchronous to i_sys_clk; fifo levels come from the fifos
`timescale 1ns/10ps
// Operation
// - report tx level 6:4, rx level 2:0
// - slave clock from pin or first unit
// - master data from pin or second unit
// - slave data select bit 0, resets zero
module sfs_spi_fifo_count_and_input_select
    import sfs_pkg::*;
#(
    parameter int LEVEL_WIDTH = SFS_LEVEL_WIDTH
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // sfr bus
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // fifo levels
    input wire logic [LEVEL_WIDTH-1:0] i_transmit_fill_level,
    input wire logic [LEVEL_WIDTH-1:0] i_receive_fill_level,
    // candidate sources
    input wire logic i_pin_sck,
    input wire logic i_pin_miso,
    input wire logic i_pin_mosi,
    input wire logic i_first_logic_unit_output,
    input wire logic i_second_logic_unit_output,
    input wire logic i_slave_data_logic_unit_output,
    // routed inputs to the shifter
    output logic o_slave_clock,
    output logic o_master_data,
    output logic o_slave_data,
    // select bits for visibility
    output logic [2:0] o_spi_input_source_select
);

    // the count fields are fixed at three bits each
    generate
        if (LEVEL_WIDTH != SFS_LEVEL_WIDTH)
        begin : g_bad_width
            $error("level width must match the 3-bit count fields");
        end
    endgenerate

    // stored select bits; reserved bits 7:3 are not kept
    logic [2:0] spi_input_source_select;
    logic [2:0] next_spi_input_source_select;

    // snapshot of the fifo levels
    logic [LEVEL_WIDTH-1:0] transmit_fill_level;
    logic [LEVEL_WIDTH-1:0] receive_fill_level;

    // address decode and qualified strobes
    logic hit_fill_counts;
    logic hit_source_select;
    logic write_select;
    logic read_counts;
    logic read_select;

    // read data path
    logic [7:0] next_sfr_rdata;
    logic [7:0] counts_word;
    logic [7:0] select_word;

    // count register address
    always_comb
    begin
        hit_fill_counts = (i_sfr_addr == SFS_FILL_COUNTS_ADDR);
    end

    // select register address
    always_comb
    begin
        hit_source_select = (i_sfr_addr == SFS_SOURCE_SELECT_ADDR);
    end

    // writes to the count register or unmapped addresses fall through
    always_comb
    begin
        write_select = i_sfr_wr && hit_source_select;
    end

    // reads of unmapped addresses return zero
    always_comb
    begin
        read_counts = i_sfr_rd && hit_fill_counts;
        read_select = i_sfr_rd && hit_source_select;
    end

    // levels are registered so a read sees one coherent snapshot
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            transmit_fill_level <= SFS_LEVEL_RESET;
            receive_fill_level <= SFS_LEVEL_RESET;
        end
        else
        begin
            transmit_fill_level <= i_transmit_fill_level;
            receive_fill_level <= i_receive_fill_level;
        end
    end

    // next select value: only the three select bits of a write are kept
    always_comb
    begin
        next_spi_input_source_select = spi_input_source_select;
        if (write_select)
        begin
            next_spi_input_source_select[SFS_SLAVE_CLOCK_BIT] =
                i_sfr_wdata[SFS_SLAVE_CLOCK_BIT];
            next_spi_input_source_select[SFS_MASTER_DATA_BIT] =
                i_sfr_wdata[SFS_MASTER_DATA_BIT];
            next_spi_input_source_select[SFS_SLAVE_DATA_BIT] =
                i_sfr_wdata[SFS_SLAVE_DATA_BIT];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            spi_input_source_select <= SFS_SELECT_RESET;
        end
        else
        begin
            spi_input_source_select <= next_spi_input_source_select;
        end
    end

    // reserved bits 7 and 3 read as zero
    always_comb
    begin
        counts_word = 8'h00;
        counts_word[SFS_TX_LEVEL_LSB +: LEVEL_WIDTH] = transmit_fill_level;
        counts_word[SFS_RX_LEVEL_LSB +: LEVEL_WIDTH] = receive_fill_level;
    end

    // reserved bits 7:3 read as zero
    always_comb
    begin
        select_word = 8'h00;
        select_word[SFS_SLAVE_CLOCK_BIT] = spi_input_source_select[SFS_SLAVE_CLOCK_BIT];
        select_word[SFS_MASTER_DATA_BIT] = spi_input_source_select[SFS_MASTER_DATA_BIT];
        select_word[SFS_SLAVE_DATA_BIT] = spi_input_source_select[SFS_SLAVE_DATA_BIT];
    end

    // idle cycles read as zero
    always_comb
    begin
        if (read_counts)
        begin
            next_sfr_rdata = counts_word;
        end
        else if (read_select)
        begin
            next_sfr_rdata = select_word;
        end
        else
        begin
            next_sfr_rdata = SFS_READ_IDLE;
        end
    end

    // read data stands one cycle, then back to zero
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_sfr_rdata <= SFS_READ_IDLE;
        end
        else
        begin
            o_sfr_rdata <= next_sfr_rdata;
        end
    end

    // plain muxes: a glitch on select change is the caller's concern
    always_comb
    begin
        if (spi_input_source_select[SFS_SLAVE_CLOCK_BIT])
        begin
            o_slave_clock = i_first_logic_unit_output;
        end
        else
        begin
            o_slave_clock = i_pin_sck;
        end
    end

    // master data source
    always_comb
    begin
        if (spi_input_source_select[SFS_MASTER_DATA_BIT])
        begin
            o_master_data = i_second_logic_unit_output;
        end
        else
        begin
            o_master_data = i_pin_miso;
        end
    end

    // which logic unit feeds slave data is open, so it is its own input
    always_comb
    begin
        if (spi_input_source_select[SFS_SLAVE_DATA_BIT])
        begin
            o_slave_data = i_slave_data_logic_unit_output;
        end
        else
        begin
            o_slave_data = i_pin_mosi;
        end
    end

    assign o_spi_input_source_select = spi_input_source_select;
endmodule

/* File: tb/sfs_monitor.sv */
// checker: the three input-routing muxes, the fill count read and the select write of the block
// bound to the block's ports; one clock, sync reset
`timescale 1ns/10ps
module sfs_monitor
    import sfs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic [2:0] i_transmit_fill_level,
    input wire logic [2:0] i_receive_fill_level,
    input wire logic i_pin_sck,
    input wire logic i_pin_miso,
    input wire logic i_pin_mosi,
    input wire logic i_first_logic_unit_output,
    input wire logic i_second_logic_unit_output,
    input wire logic i_slave_data_logic_unit_output,
    input wire logic o_slave_clock,
    input wire logic o_master_data,
    input wire logic o_slave_data,
    input wire logic [2:0] o_spi_input_source_select
);
    wire [2:0] sel = o_spi_input_source_select;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_sck;
        o_slave_clock == (sel[2] ? i_first_logic_unit_output : i_pin_sck);
    endproperty
    property p_miso;
        o_master_data == (sel[1] ? i_second_logic_unit_output : i_pin_miso);
    endproperty
    property p_mosi;
        o_slave_data == (sel[0] ? i_slave_data_logic_unit_output : i_pin_mosi);
    endproperty
    sequence s_counts_read;
        i_sfr_rd && i_sfr_addr == SFS_FILL_COUNTS_ADDR;
    endsequence
    sequence s_select_write;
        i_sfr_wr && i_sfr_addr == SFS_SOURCE_SELECT_ADDR;
    endsequence
    // levels pass a snapshot flop, so the read shows them two edges late
    property p_counts;
        s_counts_read |=> o_sfr_rdata == {1'b0, $past(i_transmit_fill_level, 2),
            1'b0, $past(i_receive_fill_level, 2)};
    endproperty
    property p_select_write;
        s_select_write |=> o_spi_input_source_select == $past(i_sfr_wdata[2:0]);
    endproperty
    a_sck: assert property (p_sck) else $error("slave clock mux");
    a_miso: assert property (p_miso) else $error("master data mux");
    a_mosi: assert property (p_mosi) else $error("slave data mux");
    a_counts: assert property (p_counts) else $error("fill count read");
    a_select_write: assert property (p_select_write) else $error("select write");
endmodule
bind sfs_spi_fifo_count_and_input_select sfs_monitor u_mon(.*);

/* File: tb/sfs_far_side.sv */
// far side: pin and logic-unit sources, moving every cycle
// no frames here, so no line stands still for more than two cycles
`timescale 1ns/10ps
module sfs_far_side(input wire logic i_sys_clk, output logic [5:0] o_src);
    initial o_src = 6'h15;
    always @(posedge i_sys_clk) o_src <= {o_src[4:0], ~o_src[5]};
endmodule

/* File: tb/sfs_spi_fifo_count_and_input_select_tb.sv */
// bench: sfr reads and writes with expected read data
// far-side model drives all candidate sources
`timescale 1ns/10ps
module sfs_spi_fifo_count_and_input_select_tb
    import sfs_pkg::*;
;
    logic i_sys_clk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_pin_sck, i_pin_miso, i_pin_mosi;
    logic i_first_logic_unit_output, i_second_logic_unit_output, i_slave_data_logic_unit_output;
    logic o_slave_clock, o_master_data, o_slave_data;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
    logic [2:0] i_transmit_fill_level = 3'h0, i_receive_fill_level = 3'h0, o_spi_input_source_select;
    int err_total = 0, num_checks = 0, cyc = 0;
    sfs_spi_fifo_count_and_input_select u_dut(.*);
    sfs_far_side u_far(.i_sys_clk, .o_src({i_pin_sck, i_pin_miso, i_pin_mosi,
        i_first_logic_unit_output, i_second_logic_unit_output, i_slave_data_logic_unit_output}));
    initial forever #25 i_sys_clk = ~i_sys_clk;
    task automatic give_verdict;
        if (err_total == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, want);
        num_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // one access; hands back the read data of the cycle after the strobe
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge i_sys_clk);
        {i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} <= {w, !w, a, d};
        @(posedge i_sys_clk);
        {i_sfr_wr, i_sfr_rd} <= 2'h0;
        #1;
        q = o_sfr_rdata;
    endtask
    initial
    begin
        logic [7:0] q;
        logic exp_bit;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 0;
        acc(0, SFS_SOURCE_SELECT_ADDR, 8'h00, q);
        check(q, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            {i_transmit_fill_level, i_receive_fill_level} <= {3'(s), 3'(~s)};
            acc(1, SFS_SOURCE_SELECT_ADDR, {5'h1F, 3'(s)}, q);
            check(q, 8'h00);
            check({5'h00, o_spi_input_source_select}, {5'h00, 3'(s)});
            exp_bit = s[2] ? i_first_logic_unit_output : i_pin_sck;
            check({7'h00, o_slave_clock}, {7'h00, exp_bit});
            exp_bit = s[1] ? i_second_logic_unit_output : i_pin_miso;
            check({7'h00, o_master_data}, {7'h00, exp_bit});
            exp_bit = s[0] ? i_slave_data_logic_unit_output : i_pin_mosi;
            check({7'h00, o_slave_data}, {7'h00, exp_bit});
            acc(0, SFS_SOURCE_SELECT_ADDR, 8'h00, q);
            check(q, {5'h00, 3'(s)});
            acc(0, SFS_FILL_COUNTS_ADDR, 8'h00, q);
            check(q, {1'b0, 3'(s), 1'b0, 3'(~s)});
        end
        acc(1, SFS_FILL_COUNTS_ADDR, 8'hFF, q);
        check(q, 8'h00);
        acc(0, 8'h5A, 8'h00, q);
        check(q, 8'h00);
        acc(0, SFS_SOURCE_SELECT_ADDR, 8'h00, q);
        check(q, 8'h07);
        // second reset in mid-run must clear the select bits
        @(posedge i_sys_clk);
        i_rst <= 1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 0;
        #1;
        check({5'h00, o_spi_input_source_select}, 8'h00);
        acc(0, SFS_SOURCE_SELECT_ADDR, 8'h00, q);
        check(q, 8'h00);
        acc(0, SFS_FILL_COUNTS_ADDR, 8'h00, q);
        check(q, 8'h70);
        give_verdict();
    end
    // hang guard, well past the ~85 cycles the accesses need
    always @(posedge i_sys_clk) if (++cyc == 400) begin err_total++; give_verdict(); end
endmodule
